/* File: design/qdc_pkg.sv */
// Constants and types shared by the quad converter serial command decoder.
package qdc_pkg;

	// ****************************************
	// Serial word layout
	// ****************************************
	localparam int WORD_W = 24;
	localparam int CODE_W = 16;
	localparam int CNT_W = 5;
	localparam int CHAN_N = 4;
	localparam logic [4:0] LAST_BIT = 5'h17;
	localparam int CTRL_HI = 23;
	localparam int CTRL_LO = 16;
	localparam int LD_HI_BIT = 21;
	localparam int LD_LO_BIT = 20;
	localparam int SEL_HI_BIT = 18;
	localparam int SEL_LO_BIT = 17;
	localparam int PD_BIT = 16;

	// ****************************************
	// Commands and load modes
	// ****************************************
	localparam logic [7:0] REF_CTRL = 8'h01;
	localparam logic [23:0] REF_ON_CMD = 24'h011000;
	localparam logic [23:0] REF_OFF_CMD = 24'h012000;
	localparam logic [23:0] REF_AUTO_CMD = 24'h010000;
	localparam logic [1:0] LD_STORE = 2'h0;
	localparam logic [1:0] LD_SINGLE = 2'h1;
	localparam logic [1:0] LD_SIMUL = 2'h2;
	localparam logic [1:0] LD_BCAST = 2'h3;
	localparam logic [15:0] ZERO_SCALE = 16'h0000;
	localparam logic [15:0] MID_SCALE = 16'h8000;

	// ****************************************
	// APB register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [3:0] OUT_PAGE = 4'h1;
	localparam logic [3:0] BUF_PAGE = 4'h2;
	localparam int CTRL_LOAD_BIT = 0;
	localparam int CTRL_MASK_BIT = 1;

	typedef enum logic [1:0] {REF_AUTO, REF_ON, REF_OFF} qdc_ref_e;
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_LOCKED} qdc_state_e;

endpackage : qdc_pkg

/* File: design/qdc_sync.sv */
// Two-flop synchroniser for pins from outside the pclk domain.
`timescale 1ns/100ps
module qdc_sync #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	import qdc_pkg::*;

	logic [W-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : qdc_sync

/* File: design/qdc_chan.sv */
// One converter channel: temporary buffer, output register, reset level.
`timescale 1ns/100ps
module qdc_chan (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic buf_we,
	input wire logic out_pay,
	input wire logic out_buf,
	input wire logic [qdc_pkg::CODE_W-1:0] pay_code,
	input wire logic pay_pd,
	input wire logic level_mid,
	output logic [qdc_pkg::CODE_W-1:0] buf_code_r,
	output logic buf_pd_r,
	output logic [qdc_pkg::CODE_W-1:0] out_code_r,
	output logic out_pd_r,
	output logic loaded_r,
	output logic [qdc_pkg::CODE_W-1:0] dac_code_r
);
	import qdc_pkg::*;

	wire out_we = out_pay | out_buf;
	wire [CODE_W-1:0] out_src = out_pay ? pay_code : buf_code_r;
	wire out_src_pd = out_pay ? pay_pd : buf_pd_r;
	wire [CODE_W-1:0] idle_level = level_mid ? MID_SCALE : ZERO_SCALE;

	// Code and power-down flag travel together in both stages.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_code_r <= ZERO_SCALE;
			buf_pd_r <= 1'b0;
			out_code_r <= ZERO_SCALE;
			out_pd_r <= 1'b0;
			loaded_r <= 1'b0;
		end else begin
			if (buf_we) begin
				buf_code_r <= pay_code;
				buf_pd_r <= pay_pd;
			end
			if (out_we) begin
				out_code_r <= out_src;
				out_pd_r <= out_src_pd;
				loaded_r <= 1'b1;
			end
		end
	end

	// Until the first load the output holds the strapped reset level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dac_code_r <= ZERO_SCALE;
		end else begin
			dac_code_r <= loaded_r ? out_code_r : idle_level;
		end
	end

endmodule : qdc_chan

/* File: design/qdc_top.sv */
// Serial command decoder for a quad 16-bit converter, with APB status.
// Overview of operation
// - Word 011000h keeps reference always powered.
// - Frame select fall starts; shift on sclk fall.
// - Lock shift register after 24th bit.
// - Top eight bits control, low sixteen payload.
// - Execute right after 24th edge.
// - New frame only at next select fall.
// - Early select rise discards the partial word.
// - Reset pin clears everything asynchronously.
// - Reset level: mid-scale or zero-scale by pin.
// - Load mode, channel select, power-down flag fields.
// - Select 00, 01, 10 address A, B, C.
// - Mode 00 stores buffer only.
// - Mode 01 loads buffer and output.
// - Mode 10 loads selected, others from buffers.
// - Mode 11 broadcast from buffers or payload.
// - Power-down flag marks payload as power-down.
// - Select 11 addresses channel D.
// - 012000h disables reference, 010000h restores auto.
// - Serial disable pin high ignores serial activity.
`timescale 1ns/100ps
module qdc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [qdc_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_sync_n,
	input wire logic sclk,
	input wire logic sdin,
	input wire logic serial_disable,
	input wire logic reset_level_select,
	output logic [qdc_pkg::CODE_W-1:0] dac_a_code,
	output logic [qdc_pkg::CODE_W-1:0] dac_b_code,
	output logic [qdc_pkg::CODE_W-1:0] dac_c_code,
	output logic [qdc_pkg::CODE_W-1:0] dac_d_code,
	output logic dac_a_pd,
	output logic dac_b_pd,
	output logic dac_c_pd,
	output logic dac_d_pd,
	output logic ref_powered
);
	import qdc_pkg::*;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// The serial clock is slow against pclk, so it is sampled, not used.
	logic [4:0] pins_s;
	logic sync_prev_r;
	logic sclk_prev_r;

	// Select is carried inverted so that the flops' cleared value matches
	// its idle level; otherwise every reset release looks like a frame.
	qdc_sync #(.W(5)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({reset_level_select, serial_disable, sdin, sclk,
			~frame_sync_n}),
		.sync_out(pins_s)
	);

	wire sync_s = ~pins_s[0];
	wire sclk_s = pins_s[1];
	wire din_s = pins_s[2];
	wire dis_s = pins_s[3];
	wire lvl_s = pins_s[4];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_prev_r <= 1'b1;
			sclk_prev_r <= 1'b0;
		end else begin
			sync_prev_r <= sync_s;
			sclk_prev_r <= sclk_s;
		end
	end

	wire sync_fall = sync_prev_r & ~sync_s;
	wire sclk_fall = sclk_prev_r & ~sclk_s;

	// ****************************************
	// Frame receiver
	// ****************************************
	qdc_state_e state_r;
	qdc_state_e state_nxt;
	logic [CNT_W-1:0] bit_cnt_r;
	logic [WORD_W-1:0] input_shift_word_r;
	logic cmd_valid_r;
	logic serial_mask_r;
	logic [7:0] frames_r;
	logic [7:0] aborts_r;

	wire serial_off = dis_s | serial_mask_r;
	wire shift_en = (state_r == ST_SHIFT) & ~sync_s & sclk_fall;
	wire last_bit = shift_en & (bit_cnt_r == LAST_BIT);
	wire abort = (state_r == ST_SHIFT) & sync_s;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (sync_fall) begin
					state_nxt = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (abort) begin
					state_nxt = ST_IDLE;
				end else if (last_bit) begin
					state_nxt = ST_LOCKED;
				end
			end
			ST_LOCKED: begin
				if (sync_s) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
		if (serial_off) begin
			state_nxt = ST_IDLE;
		end
	end

	// Reset clears every register asynchronously.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= '0;
			input_shift_word_r <= '0;
			cmd_valid_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cmd_valid_r <= last_bit & ~serial_off;
			if (state_r == ST_IDLE) begin
				bit_cnt_r <= '0;
			end else if (shift_en) begin
				bit_cnt_r <= bit_cnt_r + 1'b1;
				input_shift_word_r <= {input_shift_word_r[WORD_W-2:0], din_s};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frames_r <= '0;
			aborts_r <= '0;
		end else begin
			frames_r <= frames_r + {7'h00, cmd_valid_r};
			aborts_r <= aborts_r + {7'h00, abort};
		end
	end

	// ****************************************
	// Command decode
	// ****************************************
	// Bits 23, 22 and 19 are not checked; the host keeps them zero.
	wire [7:0] ctrl = input_shift_word_r[CTRL_HI:CTRL_LO];
	wire [CODE_W-1:0] payload = input_shift_word_r[CODE_W-1:0];
	wire [1:0] ld_mode = {input_shift_word_r[LD_HI_BIT],
		input_shift_word_r[LD_LO_BIT]};
	wire [1:0] chan_sel = {input_shift_word_r[SEL_HI_BIT],
		input_shift_word_r[SEL_LO_BIT]};
	wire powerdown_select_flag = input_shift_word_r[PD_BIT];
	wire bcast_pay = input_shift_word_r[SEL_HI_BIT];
	wire is_ref = cmd_valid_r & (ctrl == REF_CTRL);
	wire is_dac = cmd_valid_r & ~is_ref;
	wire m_store = ld_mode == LD_STORE;
	wire m_single = ld_mode == LD_SINGLE;
	wire m_simul = ld_mode == LD_SIMUL;
	wire m_bcast = ld_mode == LD_BCAST;
	logic sw_load_all;

	logic [CHAN_N-1:0] buf_we;
	logic [CHAN_N-1:0] out_pay;
	logic [CHAN_N-1:0] out_buf;
	logic [CODE_W-1:0] buf_code [CHAN_N];
	logic [CODE_W-1:0] out_code [CHAN_N];
	logic [CODE_W-1:0] dac_code [CHAN_N];
	logic [CHAN_N-1:0] buf_pd;
	logic [CHAN_N-1:0] out_pd;
	logic [CHAN_N-1:0] loaded;

	genvar ch;
	generate
		for (ch = 0; ch < CHAN_N; ch++) begin : g_chan
			wire hit = chan_sel == 2'(ch);
			assign buf_we[ch] = is_dac & ((~m_bcast & hit)
				| (m_bcast & bcast_pay));
			assign out_pay[ch] = is_dac & (((m_single | m_simul) & hit)
				| (m_bcast & bcast_pay));
			assign out_buf[ch] = sw_load_all | (is_dac & ((m_simul & ~hit)
				| (m_bcast & ~bcast_pay)));
			qdc_chan u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.buf_we(buf_we[ch]),
				.out_pay(out_pay[ch]),
				.out_buf(out_buf[ch]),
				.pay_code(payload),
				.pay_pd(powerdown_select_flag),
				.level_mid(lvl_s),
				.buf_code_r(buf_code[ch]),
				.buf_pd_r(buf_pd[ch]),
				.out_code_r(out_code[ch]),
				.out_pd_r(out_pd[ch]),
				.loaded_r(loaded[ch]),
				.dac_code_r(dac_code[ch])
			);
		end
	endgenerate

	assign dac_a_code = dac_code[0];
	assign dac_b_code = dac_code[1];
	assign dac_c_code = dac_code[2];
	assign dac_d_code = dac_code[3];
	assign dac_a_pd = out_pd[0];
	assign dac_b_pd = out_pd[1];
	assign dac_c_pd = out_pd[2];
	assign dac_d_pd = out_pd[3];

	// ****************************************
	// Reference control
	// ****************************************
	qdc_ref_e ref_mode_r;
	wire ref_on_cmd = is_ref & (input_shift_word_r == REF_ON_CMD);
	wire ref_off_cmd = is_ref & (input_shift_word_r == REF_OFF_CMD);
	wire ref_auto_cmd = is_ref & (input_shift_word_r == REF_AUTO_CMD);
	wire any_up = ~&out_pd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_mode_r <= REF_AUTO;
			ref_powered <= 1'b0;
		end else begin
			if (ref_on_cmd) begin
				ref_mode_r <= REF_ON;
			end else if (ref_off_cmd) begin
				ref_mode_r <= REF_OFF;
			end else if (ref_auto_cmd) begin
				ref_mode_r <= REF_AUTO;
			end
			ref_powered <= (ref_mode_r == REF_ON)
				| ((ref_mode_r == REF_AUTO) & any_up);
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	// Zero wait states: read data is caught in the setup cycle.
	logic [31:0] prdata_r;
	logic err_r;
	wire setup = psel & ~penable;
	wire wr_acc = psel & penable & pwrite;
	wire ctrl_hit = paddr == CTRL_OFS;
	wire stat_hit = paddr == STAT_OFS;
	wire [1:0] ridx = paddr[3:2];
	wire word_ok = paddr[1:0] == 2'h0;
	wire out_hit = word_ok & (paddr[7:4] == OUT_PAGE);
	wire buf_hit = word_ok & (paddr[7:4] == BUF_PAGE);
	wire any_hit = ctrl_hit | stat_hit | out_hit | buf_hit;
	wire [31:0] ctrl_rd = {30'h0, serial_mask_r, 1'b0};
	wire [31:0] stat_rd = {8'h00, aborts_r, frames_r, 4'h0,
		state_r, ref_mode_r};
	wire [31:0] out_rd = {15'h0000, out_pd[ridx], out_code[ridx]};
	wire [31:0] buf_rd = {15'h0000, buf_pd[ridx], buf_code[ridx]};
	wire [31:0] rd_mux = ctrl_hit ? ctrl_rd : stat_hit ? stat_rd
		: out_hit ? out_rd : buf_hit ? buf_rd : 32'h0000_0000;

	assign sw_load_all = wr_acc & ctrl_hit & pwdata[CTRL_LOAD_BIT];
	assign pready = 1'b1;
	assign pslverr = psel & penable & err_r;
	assign prdata = prdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
			err_r <= 1'b0;
			serial_mask_r <= 1'b0;
		end else begin
			if (setup) begin
				prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
				err_r <= ~any_hit;
			end
			if (wr_acc & ctrl_hit) begin
				serial_mask_r <= pwdata[CTRL_MASK_BIT];
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_ref_always_on: assert property (ref_on_cmd |=> ref_mode_r == REF_ON
		##1 ref_powered) else $error("reference not held on");
	a_frame_start: assert property ((state_r == ST_IDLE) && sync_fall
		&& !serial_off |=> state_r == ST_SHIFT && bit_cnt_r == '0)
		else $error("frame did not start");
	a_word_locked: assert property ((state_r == ST_LOCKED) && sclk_fall
		|=> $stable(input_shift_word_r))
		else $error("locked word changed");
	a_exec_now: assert property (last_bit && !serial_off
		|=> cmd_valid_r && state_r == ST_LOCKED)
		else $error("command not executed at last bit");
	a_abort_drop: assert property (abort |=> !cmd_valid_r
		&& state_r != ST_LOCKED)
		else $error("partial word not discarded");
	a_single_load: assert property (is_dac && m_single
		|=> out_code[$past(chan_sel)] == $past(payload))
		else $error("single update missed");
	a_store_only: assert property (is_dac && m_store && !sw_load_all
		|=> out_code[$past(chan_sel)] == $past(out_code[chan_sel]))
		else $error("store changed output");
	a_simul_load: assert property (is_dac && m_simul && chan_sel == 2'h0
		|=> out_code[1] == $past(buf_code[1]))
		else $error("simultaneous update missed");
	a_ref_no_touch: assert property (is_ref |=> $stable(buf_code[0])
		&& $stable(buf_code[3]))
		else $error("reference command touched channel");
	a_serial_off: assert property (serial_off |=> state_r == ST_IDLE
		##1 !cmd_valid_r) else $error("serial not ignored");
	a_reset_level: assert property (!loaded[0] && lvl_s && $stable(lvl_s)
		|=> dac_code[0] == MID_SCALE)
		else $error("reset level wrong");
	a_ref_off: assert property (ref_off_cmd |=> ##1 !ref_powered)
		else $error("reference not disabled");

	c_full_frame: cover property (cmd_valid_r && m_single);
	c_abort: cover property (abort);
	c_broadcast: cover property (is_dac && m_bcast && bcast_pay);
	c_ref_cmd: cover property (ref_on_cmd);

endmodule : qdc_top

/* File: bench/qdc_host.sv */
// Serial host model that drives command frames into the decoder.
`timescale 1ns/100ps
module qdc_host (
	output logic frame_sync_n,
	output logic sclk,
	output logic sdin
);
	initial begin
		frame_sync_n = 1'b1;
		sclk = 1'b1;
		sdin = 1'b0;
	end

	// The clock idles high between frames and is never free running.
	// Data flips once released so a stale bit is never mistaken for valid.
	// Bits past the 24th carry toggling junk to prove the word is locked.
	task automatic send(input logic [23:0] w, input int n);
		#3 frame_sync_n = 1'b0;
		#32;
		for (int i = 0; i < n; i++) begin
			sclk = 1'b1;
			sdin = (i < 24) ? w[23-i] : ~sdin;
			#32 sclk = 1'b0;
			#32;
		end
		sclk = 1'b1;
		sdin = ~sdin;
		#32 frame_sync_n = 1'b1;
		#64;
	endtask : send
endmodule : qdc_host

/* File: bench/test_qdc_top.sv */
// Self-checking bench for the quad converter serial command decoder.
`timescale 1ns/100ps
module test_qdc_top;
	import qdc_pkg::*;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, ref_powered;
	logic serial_disable, reset_level_select, frame_sync_n, sclk, sdin;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] dac_a_code, dac_b_code, dac_c_code, dac_d_code;
	logic dac_a_pd, dac_b_pd, dac_c_pd, dac_d_pd, lvl;
	logic [16:0] bm[4], om[4];
	bit ld[4];
	logic [1:0] rm;
	logic [23:0] w;
	int n_errors, n_compared, nd, na, cyc;
	logic [32:0] rq[$];
	logic [68:0] pq[$];
	event pin_go;
	wire [68:0] pv = {dac_a_pd, dac_a_code, dac_b_pd, dac_b_code,
		dac_c_pd, dac_c_code, dac_d_pd, dac_d_code, ref_powered};

	qdc_top i_qdc_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .frame_sync_n, .sclk, .sdin,
		.serial_disable, .reset_level_select, .dac_a_code, .dac_b_code,
		.dac_c_code, .dac_d_code, .dac_a_pd, .dac_b_pd, .dac_c_pd,
		.dac_d_pd, .ref_powered);
	qdc_host i_qdc_host (.frame_sync_n, .sclk, .sdin);

	always #4 pclk = ~pclk;

	task automatic check(input string nm, input logic [68:0] s,
		input logic [68:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : check

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite)
			check("apb", 69'({pslverr, prdata}), 69'(rq.pop_front()));
	end
	always @(pin_go) check("pins", pv, pq.pop_front());

	task automatic close_out();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	// The ceiling leaves ample margin over roughly seven thousand cycles.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			close_out();
		end
	end

	function automatic logic [68:0] exp_pins();
		logic [68:0] v;
		logic up;
		up = 1'b0;
		v = '0;
		for (int c = 0; c < 4; c++) begin
			up |= !(ld[c] && om[c][16]);
			v[68-17*c -: 17] = ld[c] ? om[c] :
				{1'b0, lvl ? MID_SCALE : ZERO_SCALE};
		end
		v[0] = (rm == 2'h1) || (rm == 2'h0 && up);
		return v;
	endfunction : exp_pins

	function automatic void apply(input logic [23:0] x);
		logic [1:0] md, s;
		logic [16:0] p;
		md = x[21:20];
		s = x[18:17];
		p = x[16:0];
		if (x[23:16] == REF_CTRL) begin
			if (x == REF_ON_CMD) rm = 2'h1;
			if (x == REF_OFF_CMD) rm = 2'h2;
			if (x == REF_AUTO_CMD) rm = 2'h0;
			return;
		end
		if (md != LD_BCAST) bm[s] = p;
		for (int c = 0; c < 4; c++) begin
			if (md == LD_BCAST && x[18]) begin
				bm[c] = p;
				om[c] = p;
				ld[c] = 1;
			end else if (md == LD_BCAST || (md == LD_SIMUL && c != s)) begin
				om[c] = bm[c];
				ld[c] = 1;
			end else if (md != LD_STORE && c == s) begin
				om[c] = p;
				ld[c] = 1;
			end
		end
	endfunction : apply

	function automatic logic [23:0] cmd(input logic [1:0] m,
		input logic [1:0] s, input logic p);
		return {2'b00, m, 1'b0, s, p, 16'($urandom)};
	endfunction : cmd

	function automatic logic [32:0] stat();
		return {9'h0, na[7:0], nd[7:0], 6'h0, rm};
	endfunction : stat

	task automatic expect_pins(input logic [68:0] e);
		pq.push_back(e);
		@(posedge pclk);
		#1 ->pin_go;
	endtask : expect_pins

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic frame(input logic [23:0] x, input int n, input bit take);
		i_qdc_host.send(x, n);
		if (take && n >= 24) begin
			apply(x);
			nd++;
		end else if (take) na++;
		repeat (8) @(posedge pclk);
		expect_pins(exp_pins());
	endtask : frame

	task automatic do_reset(input logic l);
		presetn <= 1'b0;
		reset_level_select <= l;
		repeat (3) @(posedge pclk);
		expect_pins('0);
		presetn <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			bm[c] = '0;
			om[c] = '0;
			ld[c] = 0;
		end
		rm = 2'h0;
		nd = 0;
		na = 0;
		lvl = l;
		repeat (6) @(posedge pclk);
		expect_pins(exp_pins());
		$display("test reset level %0d done", l);
	endtask : do_reset

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{serial_disable, reset_level_select} = '0;
		void'($urandom(32'h0a6e8103));
		do_reset(1'b0);
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 4; s++) begin
				frame(cmd(m[1:0], s[1:0], 1'b0), 24, 1);
				rd({BUF_PAGE, s[1:0], 2'b00}, {16'h0, bm[s]});
				rd({OUT_PAGE, s[1:0], 2'b00}, {16'h0, om[s]});
			end
		end
		$display("test load modes done");
		frame(cmd(LD_SINGLE, 2'h2, 1'b1), 24, 1);
		frame(cmd(LD_BCAST, 2'h2, 1'b1), 24, 1);
		frame(REF_ON_CMD, 24, 1);
		frame(24'h01ffff, 24, 1);
		frame(REF_OFF_CMD, 24, 1);
		rd(STAT_OFS, stat());
		frame(REF_AUTO_CMD, 24, 1);
		frame(cmd(LD_SINGLE, 2'h3, 1'b0), 24, 1);
		$display("test power-down and reference done");
		frame(cmd(LD_SINGLE, 2'h0, 1'b0), 10, 1);
		frame(cmd(LD_SINGLE, 2'h1, 1'b0), 23, 1);
		w = cmd(LD_SINGLE, 2'h1, 1'b0);
		apply(w);
		nd++;
		fork
			i_qdc_host.send(w, 28);
			begin
				#1700;
				expect_pins(exp_pins());
			end
		join
		expect_pins(exp_pins());
		rd(STAT_OFS, stat());
		$display("test abort and lock done");
		serial_disable <= 1'b1;
		repeat (4) @(posedge pclk);
		frame(cmd(LD_SINGLE, 2'h0, 1'b0), 24, 0);
		serial_disable <= 1'b0;
		apb(1'b1, CTRL_OFS, 32'h2);
		rd(CTRL_OFS, 33'h2);
		frame(cmd(LD_SINGLE, 2'h0, 1'b0), 24, 0);
		apb(1'b1, CTRL_OFS, 32'h0);
		frame(cmd(LD_STORE, 2'h0, 1'b0), 24, 1);
		apb(1'b1, CTRL_OFS, 32'h1);
		for (int c = 0; c < 4; c++) begin
			om[c] = bm[c];
			ld[c] = 1;
		end
		repeat (4) @(posedge pclk);
		expect_pins(exp_pins());
		rd(CTRL_OFS, 33'h0);
		apb(1'b1, 8'h40, 32'hffff);
		rd(8'h40, {1'b1, 32'h0});
		rd(STAT_OFS, stat());
		$display("test register bus done");
		do_reset(1'b1);
		frame(cmd(LD_SIMUL, 2'h1, 1'b0), 24, 1);
		rd(STAT_OFS, stat());
		$display("test second reset done");
		close_out();
	end
endmodule : test_qdc_top
